// ==== sarc_top.sv ====
// converter control: mode and channel registers, timing, sequencer, results
`timescale 1ns/1ps
`include "sarc_params.svh"
module sarc_top #(
	parameter int DIV_WIDTH = 4
) (
	input  wire logic                   clk_sys,           // peripheral clock, 125 MHz
	input  wire logic                   reset_n,           // async reset, active low
	input  wire sarc_pkg::sarc_bus_req_t bus_req,          // cpu request
	output logic                        bus_ready,         // request completes this edge
	output logic [15:0]                 bus_rdata,         // read data, cycle after ready
	output logic                        bus_rvalid,        // read data valid pulse
	input  wire logic [8:0]             pin_is_digital,    // from pin configuration register
	input  wire logic [8:0]             pin_is_output,     // from port direction registers
	input  wire logic                   comparator_high,   // input above tap voltage
	output sarc_pkg::sarc_analog_t      analog_ctrl,       // to analog front end
	output logic                        conversion_done_irq // end-of-conversion pulse
);

	// ------------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------------
	logic [7:0]            converter_mode_reg;
	logic [3:0]            analog_channel_select;
	logic [9:0]            approximation_register;
	logic [5:0]            step;
	logic [5:0]            ticks_per_conv;
	logic [DIV_WIDTH-1:0]  div_ratio;
	logic                  wait_done;
	logic                  needs_wait;
	logic                  take;
	logic                  wr_mode;
	logic                  wr_chan;
	logic                  rd_take;
	logic                  run;
	logic                  conv_restart;
	logic                  tick;
	logic                  last_tick;
	logic                  end_of_conv;
	logic [9:0]            final_value;
	logic [15:0]           result_word;
	logic [7:0]            result_high;
	logic [15:0]           next_rdata;
	logic [8:0]            chan_onehot;
	logic [3:0]            bitpos;
	sarc_pkg::sarc_state_t state;
	sarc_pkg::sarc_state_t next_state;

	// ------------------------------------------------------------------------
	// bus decode and wait cycle
	// ------------------------------------------------------------------------
	// result reads and mode/channel writes stretch by one wait cycle
	assign needs_wait = bus_req.sel && (
		(!bus_req.we && (bus_req.addr == `SARC_ADDR_RESULT_LO ||
			bus_req.addr == `SARC_ADDR_RESULT_HI)) ||
		(bus_req.we && (bus_req.addr == `SARC_ADDR_CHANNEL ||
			bus_req.addr == `SARC_ADDR_MODE)));

	assign bus_ready = bus_req.sel && (!needs_wait || wait_done);
	assign take      = bus_req.sel && bus_ready;
	assign wr_mode   = take && bus_req.we && (bus_req.addr == `SARC_ADDR_MODE);
	assign wr_chan   = take && bus_req.we && (bus_req.addr == `SARC_ADDR_CHANNEL);
	assign rd_take   = take && !bus_req.we;

	// wait flag: set in the first cycle of a stretched access
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wait_done <= 1'b0;
		end else if (take) begin
			wait_done <= 1'b0;
		end else begin
			wait_done <= needs_wait;
		end
	end

	// ------------------------------------------------------------------------
	// mode register
	// ------------------------------------------------------------------------
	// bit 6 has no storage and reads zero
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			converter_mode_reg <= `SARC_RESET_MODE;
		end else if (wr_mode) begin
			converter_mode_reg <= bus_req.wdata & `SARC_MODE_WRITE_MASK;
		end
	end

	assign run = converter_mode_reg[`SARC_MODE_RUN_BIT];

	// ------------------------------------------------------------------------
	// channel select register
	// ------------------------------------------------------------------------
	// upper bits are not stored, so a stray one there cannot steer the mux;
	// bit writes arrive as byte read-modify-write from the cpu
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			analog_channel_select <= `SARC_RESET_CHANNEL;
		end else if (wr_chan) begin
			analog_channel_select <= bus_req.wdata[`SARC_CHAN_MSB:0];
		end
	end

	// ------------------------------------------------------------------------
	// conversion timing table
	// ------------------------------------------------------------------------
	// unlisted codes fall back to the slowest divider, the safest clock
	always_comb begin
		div_ratio      = DIV_WIDTH'(`SARC_DIV_12);
		ticks_per_conv = `SARC_TICKS_LV_NORMAL;
		if (converter_mode_reg[`SARC_MODE_LV_MSB:`SARC_MODE_LV_LSB] == 2'b01) begin
			ticks_per_conv = `SARC_TICKS_LV_LOW;
		end
		unique case (converter_mode_reg[`SARC_MODE_FR_MSB:`SARC_MODE_FR_LSB])
			3'h0: div_ratio = DIV_WIDTH'(`SARC_DIV_12);
			3'h1: div_ratio = DIV_WIDTH'(`SARC_DIV_8);
			3'h2: div_ratio = DIV_WIDTH'(`SARC_DIV_6);
			3'h3: div_ratio = DIV_WIDTH'(`SARC_DIV_4);
			3'h4: div_ratio = DIV_WIDTH'(`SARC_DIV_3);
			3'h5: div_ratio = DIV_WIDTH'(`SARC_DIV_2);
			default: div_ratio = DIV_WIDTH'(`SARC_DIV_12);
		endcase
	end

	// ------------------------------------------------------------------------
	// conversion clock
	// ------------------------------------------------------------------------
	// any mode or channel write restarts the sequence, so a half-done
	// conversion never lands with stale settings
	assign conv_restart = (state == sarc_pkg::SARC_IDLE) || wr_mode || wr_chan;

	sarc_clkdiv #(
		.WIDTH   (DIV_WIDTH)
	) u_clkdiv (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.restart (conv_restart),
		.ratio   (div_ratio),
		.tick    (tick)
	);

	// ------------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------------
	// step counts conversion clock periods; sampling takes all but the last
	// ten, then one period per result bit, so ticks * ratio clocks in total
	assign last_tick   = (step == ticks_per_conv - 6'd1);
	assign end_of_conv = (state == sarc_pkg::SARC_COMPARE) && tick && last_tick
		&& !wr_mode && !wr_chan;
	assign bitpos      = 4'(ticks_per_conv - 6'd1 - step);

	always_comb begin
		next_state = state;
		unique case (state)
			sarc_pkg::SARC_IDLE: begin
				if (run) begin
					next_state = sarc_pkg::SARC_SAMPLE;
				end
			end
			sarc_pkg::SARC_SAMPLE: begin
				if (tick && step == ticks_per_conv - 6'd11) begin
					next_state = sarc_pkg::SARC_COMPARE;
				end
			end
			sarc_pkg::SARC_COMPARE: begin
				if (tick && last_tick) begin
					next_state = sarc_pkg::SARC_SAMPLE;                // back to back conversions
				end
			end
			default: next_state = sarc_pkg::SARC_IDLE;
		endcase
		if (!run) begin
			next_state = sarc_pkg::SARC_IDLE;
		end else if (wr_mode || wr_chan) begin
			next_state = sarc_pkg::SARC_SAMPLE;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= sarc_pkg::SARC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// step counter within one conversion
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			step <= 6'd0;
		end else if (conv_restart) begin
			step <= 6'd0;
		end else if (tick) begin
			step <= last_tick ? 6'd0 : step + 6'd1;
		end
	end

	// ------------------------------------------------------------------------
	// approximation register
	// ------------------------------------------------------------------------
	// trial bit is set one period ahead of its decision
	always_comb begin
		final_value = approximation_register;
		if (!comparator_high) begin
			final_value[bitpos] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			approximation_register <= `SARC_RESET_RESULT;
		end else if (conv_restart) begin
			approximation_register <= `SARC_RESET_RESULT;
		end else if (tick) begin
			if (state == sarc_pkg::SARC_SAMPLE && step == ticks_per_conv - 6'd11) begin
				approximation_register <= 10'h200;                     // msb trial
			end else if (state == sarc_pkg::SARC_COMPARE) begin
				approximation_register <= final_value;
				if (bitpos != 4'd0) begin
					approximation_register[bitpos - 4'd1] <= 1'b1;     // next trial
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// result registers
	// ------------------------------------------------------------------------
	sarc_result_regs #(
		.BITS        (`SARC_RESULT_BITS)
	) u_result (
		.clk_sys     (clk_sys),
		.reset_n     (reset_n),
		.load        (end_of_conv),
		.value       (final_value),
		.result_word (result_word),
		.result_high (result_high)
	);

	// done request, one clock, together with the result update
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			conversion_done_irq <= 1'b0;
		end else begin
			conversion_done_irq <= end_of_conv;
		end
	end

	// ------------------------------------------------------------------------
	// read data
	// ------------------------------------------------------------------------
	// a byte read at the low result address returns the two low result
	// bits; software is expected to use the word read there
	always_comb begin
		next_rdata = 16'h0000;
		unique case (bus_req.addr)
			`SARC_ADDR_RESULT_LO: begin
				next_rdata = bus_req.word ? result_word
					: {8'h00, result_word[7:0]};
			end
			`SARC_ADDR_RESULT_HI: next_rdata = {8'h00, result_high};
			`SARC_ADDR_MODE:      next_rdata = {8'h00, converter_mode_reg};
			`SARC_ADDR_CHANNEL:   next_rdata = {12'h000, analog_channel_select};
			default:              next_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			bus_rdata  <= 16'h0000;
			bus_rvalid <= 1'b0;
		end else begin
			bus_rvalid <= rd_take;
			if (rd_take) begin
				bus_rdata <= next_rdata;
			end
		end
	end

	// ------------------------------------------------------------------------
	// analog front-end control
	// ------------------------------------------------------------------------
	// switch closes only for an analog-configured pin in input mode
	generate
		for (genvar i = 0; i < `SARC_CHAN_COUNT; i++) begin : g_sel
			assign chan_onehot[i] = (analog_channel_select == 4'(i))
				&& !pin_is_output[i]
				&& !pin_is_digital[i];
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			analog_ctrl <= '0;
		end else begin
			analog_ctrl.comparator_on <= converter_mode_reg[`SARC_MODE_CE_BIT] || run;
			analog_ctrl.sample        <= (next_state == sarc_pkg::SARC_SAMPLE);
			analog_ctrl.input_select  <= chan_onehot;
			analog_ctrl.tap_code      <= approximation_register;
		end
	end

endmodule : sarc_top

// ==== sarc_params.svh ====
// offsets, field positions, reset values and timing counts of the converter control block
`ifndef SARC_PARAMS_SVH
`define SARC_PARAMS_SVH

// ----------------------------------------------------------------------------
// register addresses on the cpu internal bus
// ----------------------------------------------------------------------------
`define SARC_ADDR_RESULT_LO     16'hff18
`define SARC_ADDR_RESULT_HI     16'hff19
`define SARC_ADDR_MODE          16'hff2a
`define SARC_ADDR_CHANNEL       16'hff2b

// ----------------------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------------------
`define SARC_MODE_RUN_BIT       7
`define SARC_MODE_FR_MSB        5
`define SARC_MODE_FR_LSB        3
`define SARC_MODE_LV_MSB        2
`define SARC_MODE_LV_LSB        1
`define SARC_MODE_CE_BIT        0
`define SARC_MODE_WRITE_MASK    8'hbf

// ----------------------------------------------------------------------------
// channel select register fields
// ----------------------------------------------------------------------------
`define SARC_CHAN_MSB           3
`define SARC_CHAN_COUNT         9

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SARC_RESET_MODE         8'h00
`define SARC_RESET_CHANNEL      4'h0
`define SARC_RESET_RESULT       10'h000

// ----------------------------------------------------------------------------
// conversion timing, in conversion clock periods and peripheral clocks
// ----------------------------------------------------------------------------
`define SARC_RESULT_BITS        10
`define SARC_TICKS_LV_NORMAL    6'd22
`define SARC_TICKS_LV_LOW       6'd40
`define SARC_DIV_12             4'd12
`define SARC_DIV_8              4'd8
`define SARC_DIV_6              4'd6
`define SARC_DIV_4              4'd4
`define SARC_DIV_3              4'd3
`define SARC_DIV_2              4'd2
`define SARC_FPRS_MHZ           125

`endif

// ==== sarc_pkg.sv ====
// types shared by the converter control block
package sarc_pkg;

	// ------------------------------------------------------------------------
	// conversion sequencer states
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		SARC_IDLE    = 2'b00,
		SARC_SAMPLE  = 2'b01,
		SARC_COMPARE = 2'b10
	} sarc_state_t;

	// ------------------------------------------------------------------------
	// cpu internal bus request, held by the cpu until bus_ready
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic        sel;      // access in progress
		logic        we;       // 1 write, 0 read
		logic        word;     // 1 16-bit access, 0 8-bit access
		logic [15:0] addr;     // byte address
		logic [7:0]  wdata;    // write byte
	} sarc_bus_req_t;

	// ------------------------------------------------------------------------
	// controls toward sample-hold, resistor string and comparator
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic        comparator_on;  // comparator powered
		logic        sample;         // 1 track input, 0 hold
		logic [8:0]  input_select;   // one-hot analog input switch
		logic [9:0]  tap_code;       // resistor string tap, approximation value
	} sarc_analog_t;

endpackage : sarc_pkg

// ==== sarc_clkdiv.sv ====
// conversion clock divider: one-cycle tick every ratio peripheral clocks
`timescale 1ns/1ps
module sarc_clkdiv #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk_sys,   // peripheral clock
	input  wire logic             reset_n,   // async reset, active low
	input  wire logic             restart,   // start a fresh period
	input  wire logic [WIDTH-1:0] ratio,     // division ratio, 2 or more
	output logic                  tick       // last clock of a period
);

	logic [WIDTH-1:0] count;

	// ------------------------------------------------------------------------
	// period counter
	// ------------------------------------------------------------------------
	// restart lines the period up with conversion start, so the length of
	// a conversion is an exact multiple of the ratio
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
		end else if (restart || tick) begin
			count <= '0;
		end else begin
			count <= count + WIDTH'(1);
		end
	end

	assign tick = !restart && (count == ratio - WIDTH'(1));

endmodule : sarc_clkdiv

// ==== sarc_result_regs.sv ====
// result storage: 10-bit result, read as left-aligned word or high byte
`timescale 1ns/1ps
`include "sarc_params.svh"
module sarc_result_regs #(
	parameter int BITS = 10
) (
	input  wire logic            clk_sys,     // peripheral clock
	input  wire logic            reset_n,     // async reset, active low
	input  wire logic            load,        // end of conversion
	input  wire logic [BITS-1:0] value,       // approximation result
	output logic      [15:0]     result_word, // left-aligned, low bits zero
	output logic      [7:0]      result_high  // upper eight bits
);

	logic [BITS-1:0] result;

	// ------------------------------------------------------------------------
	// result latch
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			result <= `SARC_RESET_RESULT;
		end else if (load) begin
			result <= value;
		end
	end

	// low bits are hard zero, not stored
	assign result_word = {result, {(16 - BITS){1'b0}}};
	assign result_high = result[BITS-1 -: 8];

endmodule : sarc_result_regs

// ==== sarc_analog_model.sv ====
// behavioural analog front end: sample-hold, resistor string and comparator
`timescale 1ns/1ps
module sarc_analog_model (
	input  wire sarc_pkg::sarc_analog_t analog_ctrl,    // controls from converter
	output logic                        comparator_high // input above tap
);
	logic [9:0] level; // held level of the switched input

	// input i holds {i, 2d}; with no switch closed the node sits at ground,
	// so a blocked channel converts to zero rather than a stale level
	always_comb begin
		level = 10'h000;
		for (int i = 0; i < 9; i++)
			if (analog_ctrl.input_select[i])
				level = {i[3:0], 6'h2d};
		comparator_high = analog_ctrl.comparator_on && (level >= analog_ctrl.tap_code);
	end
endmodule : sarc_analog_model

// ==== sarc_top_chk.sv ====
// port assertions for the converter control block
`timescale 1ns/1ps
module sarc_top_chk #(
	parameter int DIV_WIDTH = 4
) (
	input wire logic                    clk_sys,             // peripheral clock
	input wire logic                    reset_n,             // async reset
	input wire sarc_pkg::sarc_bus_req_t bus_req,             // cpu request
	input wire logic                    bus_ready,           // access completes
	input wire logic [15:0]             bus_rdata,           // read data
	input wire logic                    bus_rvalid,          // read data valid
	input wire logic [8:0]              pin_is_digital,      // digital pins
	input wire logic [8:0]              pin_is_output,       // output pins
	input wire logic                    comparator_high,     // comparator
	input wire sarc_pkg::sarc_analog_t  analog_ctrl,         // analog controls
	input wire logic                    conversion_done_irq  // end pulse
);
	logic [7:0] mode;    // shadow of the mode register
	logic       rd_word; // last taken read was a word at the low address

	// shadow follows taken accesses, so run state is known without peeking inside
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mode    <= 8'h00;
			rd_word <= 1'b0;
		end else if (bus_req.sel && bus_ready) begin
			if (bus_req.we && bus_req.addr == 16'hff2a)
				mode <= bus_req.wdata & 8'hbf;
			if (!bus_req.we)
				rd_word <= bus_req.word && bus_req.addr == 16'hff18;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// one wait cycle, then completion
	sequence s_one_wait;
		!bus_ready ##1 bus_ready;
	endsequence

	property p_irq_pulse;
		conversion_done_irq |=> !conversion_done_irq [*8];
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse too long or too close");
	property p_irq_run;
		!mode[7] && !$past(mode[7]) && !$past(mode[7], 2) |-> !conversion_done_irq;
	endproperty
	a_irq_run: assert property (p_irq_run) else $error("irq while stopped");
	property p_rvalid;
		bus_req.sel && bus_ready && !bus_req.we |=> bus_rvalid;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read data late");
	property p_rd_wait;
		$rose(bus_req.sel) && !bus_req.we && bus_req.addr[15:1] == 15'h7f8c |-> s_one_wait;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("result read without one wait");
	property p_chan_wait;
		$rose(bus_req.sel) && bus_req.we && bus_req.addr == 16'hff2b |-> s_one_wait;
	endproperty
	a_chan_wait: assert property (p_chan_wait) else $error("channel write without one wait");
	property p_word_zero;
		bus_rvalid && rd_word |-> bus_rdata[5:0] == 6'h00;
	endproperty
	a_word_zero: assert property (p_word_zero) else $error("word low bits not zero");
	property p_onehot;
		$onehot0(analog_ctrl.input_select);
	endproperty
	a_onehot: assert property (p_onehot) else $error("several inputs switched");
	property p_blocked;
		$stable(pin_is_output) && $stable(pin_is_digital) |->
			(analog_ctrl.input_select & (pin_is_output | pin_is_digital)) == 9'h000;
	endproperty
	a_blocked: assert property (p_blocked) else $error("blocked pin switched");
	// comparator power is a flip-flop, so it trails the mode register by one clock
	property p_comp_on;
		analog_ctrl.comparator_on == ($past(mode[7]) | $past(mode[0]));
	endproperty
	a_comp_on: assert property (p_comp_on) else $error("comparator power wrong");
	// sample-hold must stop tracking once the run bit has been clear for two clocks
	property p_sample_stop;
		!mode[7] && !$past(mode[7]) |-> !analog_ctrl.sample;
	endproperty
	a_sample_stop: assert property (p_sample_stop) else $error("sampling while stopped");
endmodule : sarc_top_chk

bind sarc_top sarc_top_chk #(.DIV_WIDTH(DIV_WIDTH)) i_chk (
	.clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req), .bus_ready(bus_ready),
	.bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .pin_is_digital(pin_is_digital),
	.pin_is_output(pin_is_output), .comparator_high(comparator_high),
	.analog_ctrl(analog_ctrl), .conversion_done_irq(conversion_done_irq)
);

// ==== sar_adc_timing_result_channel_tb.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
module sar_adc_timing_result_channel_tb;
	logic                    clk_sys = 1'b0;
	logic                    reset_n = 1'b0;
	sarc_pkg::sarc_bus_req_t bus_req = '0;
	logic                    bus_ready, bus_rvalid, irq, cmp;
	logic [15:0]             rdata, q;
	logic [8:0]              pin_dig = 9'h000;
	logic [8:0]              pin_out = 9'h000;
	sarc_pkg::sarc_analog_t  actl;
	int                      failures = 0;
	int                      total_checks = 0;
	int                      div [6] = '{12, 8, 6, 4, 3, 2};

	// 125 MHz peripheral clock; only clock counts are checked, the band is analog
	always #4 clk_sys = ~clk_sys;

	sarc_top #(.DIV_WIDTH(4)) i_dut (
		.clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req), .bus_ready(bus_ready),
		.bus_rdata(rdata), .bus_rvalid(bus_rvalid), .pin_is_digital(pin_dig),
		.pin_is_output(pin_out), .comparator_high(cmp), .analog_ctrl(actl),
		.conversion_done_irq(irq)
	);
	sarc_analog_model i_ana (.analog_ctrl(actl), .comparator_high(cmp));

	task automatic summarize;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one bus access: request held until ready, read data taken after the take edge
	task automatic acc(input logic we, input logic wd, input logic [15:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_sys);
		#1 bus_req = '{1'b1, we, wd, a, d};
		#1;
		for (n = 0; bus_ready !== 1'b1; n++) begin
			if (n > 20) begin
				failures++;
				summarize();
			end
			@(posedge clk_sys);
			#2;
		end
		@(posedge clk_sys);
		#1 bus_req.sel = 1'b0;
		q = rdata;
	endtask : acc

	// bounded wait for the end-of-conversion pulse, n counts clocks waited
	task automatic wait_irq(output int n);
		for (n = 0; irq !== 1'b1; n++) begin
			if (n > 1200) begin
				failures++;
				summarize();
			end
			@(posedge clk_sys);
			#2;
		end
	endtask : wait_irq

	// main sequence; runs end in summarize only
	initial begin
		int n, r, c, ch, lv;
		repeat (5) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		acc(0, 1, 16'hff18, 8'h00); chk(q, 16'h0000);
		acc(0, 0, 16'hff19, 8'h00); chk(q & 16'h00ff, 16'h0000);
		acc(0, 0, 16'hff2b, 8'h00); chk(q & 16'h00ff, 16'h0000);
		acc(0, 0, 16'hff2a, 8'h00); chk(q & 16'h00ff, 16'h0000);
		acc(1, 0, 16'hff2a, 8'h7f); acc(0, 0, 16'hff2a, 8'h00); chk(q & 16'h00ff, 16'h003f);
		acc(1, 0, 16'hff18, 8'h55); acc(0, 1, 16'hff18, 8'h00); chk(q, 16'h0000);
		acc(0, 1, 16'hff00, 8'h00); chk(q, 16'h0000);
		// time codes 0 to 5 of the normal range and codes 0 to 4 of the low range, channels walked through all inputs
		for (int k = 0; k < 11; k++) begin
			r = k > 5;
			c = r ? k - 6 : k;
			ch = k % 9;
			lv = {ch[3:0], 6'h2d};
			acc(1, 0, 16'hff2b, 8'(ch));
			acc(1, 0, 16'hff2a, 8'(8'h81 | (c << 3) | (r << 1)));
			wait_irq(n);
			@(posedge clk_sys);
			#2;
			wait_irq(n);
			chk(16'(n + 1), 16'((r ? 40 : 22) * div[c]));
			acc(1, 0, 16'hff2a, 8'h01);
			acc(0, 1, 16'hff18, 8'h00); chk(q, 16'(lv << 6));
			acc(0, 0, 16'hff19, 8'h00); chk(q & 16'h00ff, 16'(lv >> 2));
			acc(0, 0, 16'hff18, 8'h00); chk(q & 16'h00ff, 16'((lv & 3) << 6));
			acc(0, 0, 16'hff2b, 8'h00); chk(q & 16'h00ff, 16'(ch));
		end
		// pin left in output mode: the switch must stay open, result reads zero
		pin_out = 9'h008;
		pin_dig = 9'h010; // pin 4 digital, selector kept off it
		acc(1, 0, 16'hff2b, 8'h03);
		acc(1, 0, 16'hff2a, 8'ha9);
		wait_irq(n);
		acc(1, 0, 16'hff2a, 8'h01);
		acc(0, 1, 16'hff18, 8'h00); chk(q, 16'h0000);
		summarize();
	end
endmodule : sar_adc_timing_result_channel_tb
